// File: hw/irq_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - comparator-one rise vectors 0x006B, rank 13
// - converter-zero done vectors 0x007B, rank 15
// - converter-two window vectors 0x008B, rank 17
// - converter-two done vectors 0x0093, rank 18
// - each source has one low/high priority bit
// - high request preempts a low routine
// - nothing preempts a high routine
// - priority bits of sources 0 to 5 reset to low
// - simultaneous requests: higher level wins
// - same level: lowest rank wins
// - sample and decode every clock
// - minimum latency five clocks, detect plus call
// - cache miss stretches the vector call
// - after return, one instruction before next call
// - equal or lower waits for return plus one
// - global enable overrides every individual enable
// - bit five masks timer two; bit six spare
// - software writing pending one raises request
// - clearing global enable blocks same-cycle requests
module irq_ctrl
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [20:0] src_event,
    input wire logic [20:0] ext_enable,
    input wire logic [20:0] ext_priority,
    input wire logic cache_miss,
    input wire logic reti,
    input wire logic instr_done,
    output logic call_busy,
    output logic isr_enter,
    output logic [15:0] vector_addr,
    output logic [4:0] vector_rank,
    output logic vector_high,
    output logic in_service_low,
    output logic in_service_high,
    output logic [20:0] pending
);

    logic [7:0] interrupt_enable_reg;
    logic [5:0] priority_select_reg;
    logic [20:0] pending_reg;
    logic [20:0] pending_next;
    logic [7:0] sfr_rdata_reg;
    irq_ctrl_pkg::ctrl_state_t state_reg;
    logic [2:0] call_cnt_reg;
    logic call_busy_reg;
    logic isr_enter_reg;
    logic [15:0] vector_addr_reg;
    logic [4:0] vector_rank_reg;
    logic vector_high_reg;
    logic active_low_reg;
    logic active_high_reg;
    logic reti_hold_reg;

    logic [20:0] src_enable;
    logic [20:0] src_priority;
    logic [20:0] candidate;
    logic [20:0] cand_high;
    logic [20:0] cand_low;
    logic high_found;
    logic low_found;
    logic [4:0] high_rank;
    logic [4:0] low_rank;
    logic global_en;
    logic ie_wr;
    logic ip_wr;
    logic take;
    logic take_high;
    logic [4:0] take_rank;
    logic [20:0] sw_set;
    logic [20:0] sw_clr;
    logic [20:0] hw_clr;

    assign ie_wr = sfr_wr && (sfr_addr == irq_ctrl_pkg::ADDR_INTERRUPT_ENABLE);
    assign ip_wr = sfr_wr && (sfr_addr == irq_ctrl_pkg::ADDR_PRIORITY_SELECT);

    // a write clearing the global bit also gates this cycle's decode
    assign global_en = interrupt_enable_reg[irq_ctrl_pkg::IE_GLOBAL_BIT]
        && !(ie_wr && !sfr_wdata[irq_ctrl_pkg::IE_GLOBAL_BIT]);

    // low sources take their enable and level from the local registers
    always_comb
    begin
        src_enable = ext_enable;
        src_priority = ext_priority;
        src_enable[irq_ctrl_pkg::IE_SRC_BITS-1:0] =
            interrupt_enable_reg[irq_ctrl_pkg::IE_SRC_BITS-1:0];
        src_priority[irq_ctrl_pkg::IE_SRC_BITS-1:0] =
            priority_select_reg;
    end

    assign candidate = pending_reg & src_enable
        & irq_ctrl_pkg::SRC_PRESENT_MASK
        & {irq_ctrl_pkg::NUM_SRC{global_en}};

    // high may come in over a low routine, never over a high one
    assign cand_high = candidate & src_priority
        & {irq_ctrl_pkg::NUM_SRC{!active_high_reg}};
    // low waits for any routine to return
    assign cand_low = candidate & ~src_priority
        & {irq_ctrl_pkg::NUM_SRC{!active_high_reg && !active_low_reg}};

    lowest_rank_pick pick_high
    (
        .req(cand_high),
        .found(high_found),
        .rank(high_rank)
    );

    lowest_rank_pick pick_low
    (
        .req(cand_low),
        .found(low_found),
        .rank(low_rank)
    );

    // level first, then fixed rank inside the level
    assign take_high = high_found;
    assign take_rank = high_found ? high_rank : low_rank;
    // returning routine blocks a call until one more instruction retires
    // entry cycle blocked: the level bit is not open yet
    assign take = (state_reg == irq_ctrl_pkg::ST_IDLE)
        && (high_found || low_found) && !isr_enter_reg
        && !reti_hold_reg && !reti;

    // software writes to the pending bytes: ones set, zeros clear
    always_comb
    begin
        sw_set = 21'h00_0000;
        sw_clr = 21'h00_0000;
        if (sfr_wr)
        begin
            unique case (sfr_addr)
                irq_ctrl_pkg::ADDR_PENDING_0:
                begin
                    sw_set[7:0] = sfr_wdata;
                    sw_clr[7:0] = ~sfr_wdata;
                end
                irq_ctrl_pkg::ADDR_PENDING_1:
                begin
                    sw_set[15:8] = sfr_wdata;
                    sw_clr[15:8] = ~sfr_wdata;
                end
                irq_ctrl_pkg::ADDR_PENDING_2:
                begin
                    sw_set[20:16] = sfr_wdata[4:0];
                    sw_clr[20:16] = ~sfr_wdata[4:0];
                end
                default:
                begin
                    sw_set = 21'h00_0000;
                    sw_clr = 21'h00_0000;
                end
            endcase
        end
    end

    // only edge-style flags are cleared when the call completes
    always_comb
    begin
        hw_clr = 21'h00_0000;
        if (isr_enter_reg)
        begin
            hw_clr[vector_rank_reg] = irq_ctrl_pkg::HW_CLEAR_MASK[vector_rank_reg];
        end
    end

    // sets win over clears so no event is lost; others stay for software
    assign pending_next = ((pending_reg & ~sw_clr & ~hw_clr)
        | sw_set | src_event) & irq_ctrl_pkg::SRC_PRESENT_MASK;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pending_reg <= irq_ctrl_pkg::PENDING_RESET;
        end
        else
        begin
            pending_reg <= pending_next;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            interrupt_enable_reg <= irq_ctrl_pkg::INTERRUPT_ENABLE_RESET;
        end
        else if (ie_wr)
        begin
            // the spare bit is stored and read back, nothing else
            interrupt_enable_reg <= sfr_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            priority_select_reg <= irq_ctrl_pkg::PRIORITY_SELECT_RESET;
        end
        else if (ip_wr)
        begin
            priority_select_reg <= sfr_wdata[irq_ctrl_pkg::IE_SRC_BITS-1:0];
        end
    end

    // read data is registered: valid the cycle after the strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sfr_rdata_reg <= 8'h00;
        end
        else if (sfr_rd)
        begin
            unique case (sfr_addr)
                irq_ctrl_pkg::ADDR_INTERRUPT_ENABLE:
                    sfr_rdata_reg <= interrupt_enable_reg;
                irq_ctrl_pkg::ADDR_PRIORITY_SELECT:
                    sfr_rdata_reg <= {irq_ctrl_pkg::PRIORITY_SELECT_UNUSED,
                        priority_select_reg};
                irq_ctrl_pkg::ADDR_PENDING_0:
                    sfr_rdata_reg <= pending_reg[7:0];
                irq_ctrl_pkg::ADDR_PENDING_1:
                    sfr_rdata_reg <= pending_reg[15:8];
                irq_ctrl_pkg::ADDR_PENDING_2:
                    sfr_rdata_reg <= {3'h0, pending_reg[20:16]};
                default:
                    sfr_rdata_reg <= 8'h00;
            endcase
        end
    end

    // decode, then four call cycles; a cache miss freezes the count
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= irq_ctrl_pkg::ST_IDLE;
            call_cnt_reg <= 3'h0;
            call_busy_reg <= 1'b0;
            isr_enter_reg <= 1'b0;
        end
        else
        begin
            isr_enter_reg <= 1'b0;
            unique case (state_reg)
                irq_ctrl_pkg::ST_IDLE:
                begin
                    if (take)
                    begin
                        state_reg <= irq_ctrl_pkg::ST_CALL;
                        call_cnt_reg <= 3'h0;
                        call_busy_reg <= 1'b1;
                    end
                end
                irq_ctrl_pkg::ST_CALL:
                begin
                    if (!cache_miss)
                    begin
                        if (call_cnt_reg == irq_ctrl_pkg::CALL_LAST)
                        begin
                            state_reg <= irq_ctrl_pkg::ST_IDLE;
                            call_busy_reg <= 1'b0;
                            isr_enter_reg <= 1'b1;
                        end
                        else
                        begin
                            call_cnt_reg <= call_cnt_reg + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // vector register holds the reset vector until the first call
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vector_addr_reg <= irq_ctrl_pkg::RESET_VECTOR;
            vector_rank_reg <= 5'h00;
            vector_high_reg <= 1'b0;
        end
        else if (take)
        begin
            // base plus eight per rank gives 0x6B, 0x7B, 0x8B, 0x93
            vector_addr_reg <= irq_ctrl_pkg::VEC_BASE
                + {8'h00, take_rank, 3'h0};
            vector_rank_reg <= take_rank;
            vector_high_reg <= take_high;
        end
    end

    // two nesting levels: return closes the highest open one
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            active_low_reg <= 1'b0;
            active_high_reg <= 1'b0;
        end
        else if (isr_enter_reg)
        begin
            if (vector_high_reg)
            begin
                active_high_reg <= 1'b1;
            end
            else
            begin
                active_low_reg <= 1'b1;
            end
        end
        else if (reti)
        begin
            if (active_high_reg)
            begin
                active_high_reg <= 1'b0;
            end
            else
            begin
                active_low_reg <= 1'b0;
            end
        end
    end

    // held from return until the next instruction retires
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reti_hold_reg <= 1'b0;
        end
        else if (reti)
        begin
            reti_hold_reg <= 1'b1;
        end
        else if (instr_done)
        begin
            reti_hold_reg <= 1'b0;
        end
    end

    assign sfr_rdata = sfr_rdata_reg;
    assign call_busy = call_busy_reg;
    assign isr_enter = isr_enter_reg;
    assign vector_addr = vector_addr_reg;
    assign vector_rank = vector_rank_reg;
    assign vector_high = vector_high_reg;
    assign in_service_low = active_low_reg;
    assign in_service_high = active_high_reg;
    assign pending = pending_reg;

endmodule

// File: hw/lowest_rank_pick.sv
`timescale 1ns/10ps
module lowest_rank_pick
(
    input wire logic [20:0] req,
    output logic found,
    output logic [4:0] rank
);

    always_comb
    begin
        found = 1'b0;
        rank = 5'h00;
        // scan from the top so the lowest index is left standing
        for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                found = 1'b1;
                rank = 5'(i);
            end
        end
    end

endmodule

// File: inc/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

    localparam int NUM_SRC = 21;
    localparam int RANK_W = 5;

    // special function register addresses
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'hA8;
    localparam logic [7:0] ADDR_PRIORITY_SELECT = 8'hB8;
    localparam logic [7:0] ADDR_PENDING_0 = 8'hC0;
    localparam logic [7:0] ADDR_PENDING_1 = 8'hC1;
    localparam logic [7:0] ADDR_PENDING_2 = 8'hC2;

    // interrupt_enable fields
    localparam int IE_GLOBAL_BIT = 7;
    localparam int IE_SPARE_BIT = 6;
    localparam int IE_TIMER_TWO_BIT = 5;
    localparam int IE_UART_ZERO_BIT = 4;
    localparam int IE_SRC_BITS = 6;
    localparam logic [7:0] INTERRUPT_ENABLE_RESET = 8'h00;

    // priority_select_reg: low six bits used, top two read as ones
    localparam logic [5:0] PRIORITY_SELECT_RESET = 6'h00;
    localparam logic [1:0] PRIORITY_SELECT_UNUSED = 2'h3;

    localparam logic [20:0] PENDING_RESET = 21'h00_0000;

    // vector layout: base plus eight bytes per rank
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    localparam logic [4:0] RANK_CMP_ONE_RISE = 5'd13;
    localparam logic [4:0] RANK_CONV0_DONE = 5'd15;
    localparam logic [4:0] RANK_CONV2_WINDOW = 5'd17;
    localparam logic [4:0] RANK_CONV2_DONE = 5'd18;
    localparam logic [4:0] RANK_RESERVED = 5'd19;
    localparam logic [15:0] VEC_CMP_ONE_RISE = 16'h006B;
    localparam logic [15:0] VEC_CONV0_DONE = 16'h007B;
    localparam logic [15:0] VEC_CONV2_WINDOW = 16'h008B;
    localparam logic [15:0] VEC_CONV2_DONE = 16'h0093;

    // sources that have a flag, and flags cleared by hardware on entry
    localparam logic [20:0] SRC_PRESENT_MASK = 21'h17_FFFF;
    localparam logic [20:0] HW_CLEAR_MASK = 21'h00_000F;

    // one clock to detect, four to make the long call
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 4;
    localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALL = 2'b01
    } ctrl_state_t;

endpackage

// File: verif/cpu_core_model.sv
`timescale 1ns/10ps
module cpu_core_model
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ret_cmd,
    input wire logic slow,
    output logic reti,
    output logic instr_done
);
    logic [2:0] wait_reg;
    // one instruction retires after each return
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reti <= 1'b0;
            instr_done <= 1'b0;
            wait_reg <= 3'h0;
        end
        else
        begin
            reti <= ret_cmd;
            instr_done <= wait_reg == 3'h1;
            if (ret_cmd)
                wait_reg <= slow ? 3'h4 : 3'h2;
            else if (wait_reg != 3'h0)
                wait_reg <= wait_reg - 3'h1;
        end
    end
endmodule

// File: verif/irq_ctrl_monitor.sv
`timescale 1ns/10ps
module irq_ctrl_monitor
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic cache_miss,
    input wire logic reti,
    input wire logic instr_done,
    input wire logic call_busy,
    input wire logic isr_enter,
    input wire logic [15:0] vector_addr,
    input wire logic [4:0] vector_rank,
    input wire logic vector_high,
    input wire logic in_service_low,
    input wire logic in_service_high,
    input wire logic [20:0] pending
);
    logic ie_wr;
    logic global_reg;
    logic hold_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    assign ie_wr = sfr_wr && sfr_addr == irq_ctrl_pkg::ADDR_INTERRUPT_ENABLE;
    // shadows of state the ports do not show
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            global_reg <= 1'b0;
        else if (ie_wr)
            global_reg <= sfr_wdata[7];
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            hold_reg <= 1'b0;
        else if (reti)
            hold_reg <= 1'b1;
        else if (instr_done)
            hold_reg <= 1'b0;
    end
    property p_latency;
        !cache_miss ##1 ($rose(call_busy) && !cache_miss) ##1 !cache_miss[*3]
            |=> isr_enter && !call_busy;
    endproperty
    a_latency: assert property (p_latency)
        else $error("vector call not four clocks");
    property p_miss;
        $rose(call_busy) ##1 cache_miss[*2] |=> !isr_enter[*3];
    endproperty
    a_miss: assert property (p_miss)
        else $error("miss did not stretch call");
    property p_vector;
        isr_enter |-> vector_addr ==
            irq_ctrl_pkg::VEC_BASE + {8'h00, vector_rank, 3'h0};
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector address off rank");
    property p_reserved;
        call_busy |-> vector_rank != irq_ctrl_pkg::RANK_RESERVED && !pending[19];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved slot used");
    property p_global;
        !global_reg |=> !$rose(call_busy);
    endproperty
    a_global: assert property (p_global)
        else $error("take with global enable off");
    property p_clear;
        ie_wr && !sfr_wdata[7] |=> !$rose(call_busy);
    endproperty
    a_clear: assert property (p_clear)
        else $error("take while global enable cleared");
    property p_high;
        in_service_high |=> !$rose(call_busy);
    endproperty
    a_high: assert property (p_high)
        else $error("high routine preempted");
    property p_preempt;
        $rose(call_busy) && $past(in_service_low) |-> vector_high;
    endproperty
    a_preempt: assert property (p_preempt)
        else $error("low routine preempted by low");
    property p_after_ret;
        reti || hold_reg |=> !$rose(call_busy);
    endproperty
    a_after_ret: assert property (p_after_ret)
        else $error("call before instruction after return");
    property p_level;
        isr_enter |=> (vector_high ? in_service_high : in_service_low);
    endproperty
    a_level: assert property (p_level)
        else $error("wrong level opened");
    c_high: cover property (isr_enter && vector_high);
    c_preempt: cover property ($rose(call_busy) && in_service_low);
    c_miss: cover property (call_busy && cache_miss);
endmodule

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [20:0] src_event = 21'h0;
    logic [20:0] ext_enable = 21'h0;
    logic [20:0] ext_priority = 21'h0;
    logic cache_miss = 1'b0;
    logic ret_cmd = 1'b0;
    logic slow = 1'b0;
    logic reti, instr_done, call_busy, isr_enter, vector_high;
    logic in_service_low, in_service_high;
    logic [7:0] sfr_rdata;
    logic [15:0] vector_addr;
    logic [4:0] vector_rank;
    logic [20:0] pending;
    int fails = 0;
    int n_compared = 0;
    int seed = 32'h4723_09e1;
    irq_ctrl i_irq_ctrl
    (
        .clk, .resetn, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata,
        .src_event, .ext_enable, .ext_priority, .cache_miss, .reti,
        .instr_done, .call_busy, .isr_enter, .vector_addr, .vector_rank,
        .vector_high, .in_service_low, .in_service_high, .pending
    );
    cpu_core_model i_cpu_core_model
    (
        .clk, .resetn, .ret_cmd, .slow, .reti, .instr_done
    );
    initial
        forever #20 clk = ~clk;
    task automatic chk(input string s, input logic [20:0] e,
        input logic [20:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 chk("sfr_rdata", 21'(e), 21'(sfr_rdata));
    endtask
    task automatic wait_enter(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end
        while (isr_enter !== 1'b1 && n < 60);
        if (n >= 60)
            fails++;
    endtask
    task automatic ret();
        @(posedge clk);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // fixed order within a level, high level first
    function automatic int pick(input logic [20:0] c, input logic [20:0] p);
        int r;
        pick = -1;
        for (r = 20; r >= 0; r--)
            if (c[r] && (p[r] || pick < 0 || !p[pick]))
                pick = r;
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #(40 * 20000);
        fails++;
        tally_and_finish();
    end
    initial
    begin
        int k, r, n;
        logic [20:0] pend, pr, c;
        logic ol, oh;
        logic [7:0] ie, p0;
        ie = irq_ctrl_pkg::ADDR_INTERRUPT_ENABLE;
        p0 = irq_ctrl_pkg::ADDR_PENDING_0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        #1 chk("vector_addr", 21'h0, 21'(vector_addr));
        rd_chk(irq_ctrl_pkg::ADDR_PRIORITY_SELECT, 8'hC0);
        rd_chk(ie, 8'h00);
        wr(irq_ctrl_pkg::ADDR_PRIORITY_SELECT, 8'h15);
        rd_chk(irq_ctrl_pkg::ADDR_PRIORITY_SELECT, 8'hD5);
        wr(irq_ctrl_pkg::ADDR_PRIORITY_SELECT, 8'h00);
        wr(ie, 8'h7F);
        rd_chk(ie, 8'h7F);
        rd_chk(8'h55, 8'h00);
        $display("test registers done");
        wr(p0, 8'h20);
        wr(ie, 8'h60);
        repeat (8) @(posedge clk);
        #1 chk("call_busy", 21'h0, 21'(call_busy));
        wr(ie, 8'hC0);
        repeat (8) @(posedge clk);
        #1 chk("call_busy", 21'h0, 21'(call_busy));
        wr(ie, 8'hA0);
        wait_enter(n);
        chk("vector_addr", 21'h2B, 21'(vector_addr));
        @(posedge clk);
        ext_enable <= 21'h10_0000;
        ext_priority <= 21'h10_0000;
        src_event <= 21'h10_0000;
        @(posedge clk);
        src_event <= 21'h0;
        wait_enter(n);
        chk("vector_rank", 21'd20, 21'(vector_rank));
        wr(p0 + 8'h02, 8'h00);
        ret();
        wr(p0, 8'h00);
        ret();
        $display("test enables done");
        for (k = 0; k < 4; k++)
        begin
            r = 13 + 2 * k - (k / 3);
            ext_enable <= 21'h1 << r;
            wr(ie, 8'h80);
            if (k == 3)
                fork
                    begin
                        @(posedge call_busy);
                        @(posedge clk) cache_miss <= 1'b1;
                        repeat (2) @(posedge clk);
                        cache_miss <= 1'b0;
                    end
                join_none
            @(posedge clk);
            src_event <= 21'h1 << r;
            @(posedge clk);
            src_event <= 21'h0;
            wait_enter(n);
            c = 21'(irq_ctrl_pkg::DETECT_CYCLES + irq_ctrl_pkg::CALL_CYCLES);
            chk("latency", c + (k == 3 ? 21'd2 : 21'd0), 21'(n));
            chk("vector_addr", 21'(3 + 8 * r), 21'(vector_addr));
            wr(p0 + 8'(r / 8), 8'h00);
            ret();
        end
        $display("test vectors done");
        // global off while the pending bytes are loaded
        wr(ie, 8'h00);
        for (k = 0; k < 8; k++)
        begin
            pend = 21'($random(seed)) & 21'h17_FFC0;
            pr = 21'($random(seed)) & 21'h1F_FFC0;
            c = 21'($random(seed)) & 21'h1F_FFC0;
            slow <= k[0];
            ext_enable <= c;
            ext_priority <= pr;
            for (r = 0; r < 3; r++)
                wr(p0 + 8'(r), 8'(pend >> (8 * r)));
            wr(ie, 8'h80);
            ol = 1'b0;
            oh = 1'b0;
            while (1)
            begin
                r = oh ? -1 : pick(pend & c & (ol ? pr : 21'h1F_FFFF), pr);
                if (r < 0 && !oh && !ol)
                    break;
                if (r < 0)
                begin
                    ret();
                    if (oh)
                        oh = 1'b0;
                    else
                        ol = 1'b0;
                end
                else
                begin
                    wait_enter(n);
                    chk("vector_rank", 21'(r), 21'(vector_rank));
                    chk("vector_high", 21'(pr[r]), 21'(vector_high));
                    pend[r] = 1'b0;
                    wr(p0 + 8'(r / 8), 8'(pend >> (r / 8 * 8)));
                    if (pr[r])
                        oh = 1'b1;
                    else
                        ol = 1'b1;
                end
            end
            wr(ie, 8'h00);
            chk("pending", pend, pending);
            for (r = 0; r < 3; r++)
                wr(p0 + 8'(r), 8'h00);
        end
        $display("test random done");
        tally_and_finish();
    end
endmodule
bind irq_ctrl irq_ctrl_monitor i_irq_ctrl_monitor
(
    .clk, .resetn, .sfr_wr, .sfr_addr, .sfr_wdata, .cache_miss, .reti,
    .instr_done, .call_busy, .isr_enter, .vector_addr, .vector_rank,
    .vector_high, .in_service_low, .in_service_high, .pending
);
